// *** pkg/adc_readout_defs.svh ***
// Constants for the serial result readout: frame layout, clamps and timing.
`ifndef ADC_READOUT_DEFS_SVH
`define ADC_READOUT_DEFS_SVH

`define FRAME_BITS     32
`define EOC_BIT        31
`define CHAN_BIT       30
`define SIGN_BIT       29
`define EXR_BIT        28
`define RES_BITS       28
`define LAST_FALL      6'd31
`define FULL_SCALE     32'sh0fffffff
`define CLAMP_HI       32'sh11ffffff
`define CLAMP_LO       32'shfe000000
`define SCK_DIV        8
`define SCK_HALF_M1    2'h3
`define SYS_CLK_MHZ    25
`define POR_TIME_US    500
`define POR_CNT_BITS   16
`define PIN_SYNC_RST   3'h3

`endif

// *** pkg/adc_readout_pkg.sv ***
// Types shared by the serial result readout.
`default_nettype none

package adc_readout_pkg;

  typedef enum logic [1:0] {
    ST_POR,
    ST_CONVERT,
    ST_SLEEP,
    ST_OUTPUT
  } rd_state_e;

  typedef struct packed {
    rd_state_e   st;
    logic [15:0] por_cnt;
    logic        mode_int;
    logic [31:0] frame;
    logic [5:0]  bit_cnt;
    logic [1:0]  div_cnt;
    logic        cs_prev;
    logic        sck_prev;
    logic        sck_out;
    logic        sck_oe_n;
    logic        sdo;
    logic        sdo_oe_n;
    logic        conv_start;
  } rd_regs_s;

endpackage

`default_nettype wire

// *** src/rd_pin_sync.sv ***
// Two-stage synchroniser for pin-level inputs.
`timescale 1ns/1ps
`default_nettype none

module rd_pin_sync #(
  parameter int               WIDTH     = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input  wire logic             sys_clk, // System clock.
  input  wire logic             arst_n,  // Asynchronous reset, active low.
  input  wire logic [WIDTH-1:0] pin_in,  // Raw asynchronous levels.
  output logic      [WIDTH-1:0] pin_out  // Synchronised levels.
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_s;

  sync_s r;
  sync_s next_r;

  initial begin
    if (WIDTH < 1) $error("rd_pin_sync: WIDTH must be at least 1");
  end

  always_comb begin
    next_r        = r;
    next_r.stage1 = pin_in;
    next_r.stage2 = r.stage1;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      // Each bit resets to the safe idle level of its pin.
      r <= '{stage1: RESET_VAL, stage2: RESET_VAL};
    end else begin
      r <= next_r;
    end
  end

  assign pin_out = r.stage2;

endmodule // rd_pin_sync

`default_nettype wire

// *** src/adc_serial_result_readout.sv ***
// Serial result readout: power-on clear, 32-bit frame and three-wire output.
`timescale 1ns/1ps
`default_nettype none
`include "adc_readout_defs.svh"

module adc_serial_result_readout #(
  parameter int CHANNELS   = 2,
  parameter int POR_CYCLES = `POR_TIME_US * `SYS_CLK_MHZ
) (
  input  wire logic        sys_clk,      // Conversion clock, 25 MHz.
  input  wire logic        arst_n,       // Asynchronous reset, active low.
  input  wire logic        supply_ok,    // Supply above reset threshold, async.
  input  wire logic        conv_done,    // Conversion finished, one-cycle pulse.
  input  wire logic [31:0] conv_value,   // Signed result, full scale 2^28-1.
  input  wire logic        conv_channel, // Channel of the finished conversion.
  input  wire logic        cs_n,         // Chip select pin, active low.
  input  wire logic        sck_in,       // Serial clock pin level.
  output logic             sck_out,      // Serial clock drive level.
  output logic             sck_oe_n,     // Serial clock drive enable, active low.
  output logic             sdo,          // Serial data out level.
  output logic             sdo_oe_n,     // Serial data out enable, active low.
  output logic             conv_start,   // New conversion begins, one-cycle pulse.
  output logic             mode_int      // Internal serial clock mode selected.
);
  import adc_readout_pkg::*;

  rd_regs_s    r;
  rd_regs_s    next_r;
  logic  [2:0] pins_s;
  logic        sup_s;
  logic        cs_s;
  logic        sck_s;
  logic        cs_fall;
  logic        cs_rise;
  logic        sck_fall;
  logic [31:0] loaded;

  initial begin
    if (CHANNELS < 1 || CHANNELS > 2) $error("CHANNELS must be 1 or 2");
    if (POR_CYCLES < 1 || POR_CYCLES > 65535) $error("POR_CYCLES out of range");
  end

  // Supply resets low so nothing counts before the pin is seen.
  rd_pin_sync #(
    .WIDTH     (3),
    .RESET_VAL (`PIN_SYNC_RST)
  ) u_sync (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .pin_in  ({supply_ok, cs_n, sck_in}),
    .pin_out (pins_s)
  );

  assign sup_s = pins_s[2];
  assign cs_s  = pins_s[1];
  assign sck_s = pins_s[0];

  // Builds the frame from a finished conversion.
  function automatic logic [31:0] pack_frame(input logic [31:0] v, input logic ch);
    logic signed [31:0] sv;
    logic signed [31:0] clamped;
    logic               sgn;
    logic               range_exceeded_flag;
    sv = signed'(v);
    if (sv > `CLAMP_HI) clamped = `CLAMP_HI;
    else if (sv < `CLAMP_LO) clamped = `CLAMP_LO;
    else clamped = sv;
    sgn = (sv >= 32'sh0);
    range_exceeded_flag = (sv < 32'sh0) || (sv > `FULL_SCALE);
    pack_frame = {1'b0, (CHANNELS == 2) ? ch : 1'b0, sgn, range_exceeded_flag,
                  clamped[`RES_BITS-1:0]};
  endfunction

  assign loaded = pack_frame(conv_value, conv_channel);

  always_comb begin
    next_r            = r;
    next_r.conv_start = 1'b0;
    next_r.cs_prev    = cs_s;
    next_r.sck_prev   = sck_s;
    cs_fall           = r.cs_prev & ~cs_s;
    cs_rise           = ~r.cs_prev & cs_s;
    sck_fall          = 1'b0;
    if (cs_fall) next_r.mode_int = sck_s;
    case (r.st)
      ST_POR: begin
        if (r.por_cnt == 16'(POR_CYCLES - 1)) begin
          next_r.st         = ST_CONVERT;
          next_r.conv_start = 1'b1;
          next_r.mode_int   = sck_s;
        end else begin
          next_r.por_cnt = r.por_cnt + 16'h1;
        end
      end
      ST_CONVERT: begin
        if (conv_done) begin
          next_r.frame = loaded;
          next_r.st    = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (!cs_s) begin
          next_r.st      = ST_OUTPUT;
          next_r.bit_cnt = 6'h0;
          next_r.div_cnt = 2'h0;
          next_r.sck_out = ~next_r.mode_int;
        end
      end
      ST_OUTPUT: begin
        if (r.mode_int) begin
          next_r.div_cnt = r.div_cnt + 2'h1;
          if (r.div_cnt == `SCK_HALF_M1) begin
            next_r.sck_out = ~r.sck_out;
            sck_fall       = r.sck_out;
          end
        end else begin
          sck_fall = r.sck_prev & ~sck_s & ~cs_s;
        end
        if (cs_rise) begin
          next_r.st         = ST_CONVERT;
          next_r.conv_start = 1'b1;
          next_r.sck_out    = 1'b1;
        end else if (sck_fall) begin
          if (r.bit_cnt == `LAST_FALL) begin
            next_r.st         = ST_CONVERT;
            next_r.conv_start = 1'b1;
            next_r.sck_out    = 1'b1;
          end else begin
            next_r.frame   = {r.frame[`FRAME_BITS-2:0], 1'b0};
            next_r.bit_cnt = r.bit_cnt + 6'h1;
          end
        end
      end
      default: next_r.st = ST_POR;
    endcase
    if (!sup_s) begin
      next_r          = '0;
      next_r.st       = ST_POR;
      next_r.cs_prev  = cs_s;
      next_r.sck_prev = sck_s;
      next_r.sck_out  = 1'b1;
    end
    next_r.sck_oe_n = ~(next_r.mode_int & (next_r.st == ST_OUTPUT) & ~cs_s);
    next_r.sdo_oe_n = cs_s | (next_r.st == ST_POR);
    next_r.sdo = (next_r.st == ST_OUTPUT) ? next_r.frame[`EOC_BIT]
                                           : (next_r.st != ST_SLEEP);
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      r          <= '0;
      r.st       <= ST_POR;
      r.cs_prev  <= 1'b1;
      r.sck_prev <= 1'b1;
      r.sck_out  <= 1'b1;
      r.sck_oe_n <= 1'b1;
      r.sdo      <= 1'b1;
      r.sdo_oe_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign sck_out    = r.sck_out;
  assign sck_oe_n   = r.sck_oe_n;
  assign sdo        = r.sdo;
  assign sdo_oe_n   = r.sdo_oe_n;
  assign conv_start = r.conv_start;
  assign mode_int   = r.mode_int;

  sequence seq_last_fall;
    (r.st == ST_OUTPUT) && !cs_rise && sck_fall && (r.bit_cnt == `LAST_FALL) && sup_s;
  endsequence

  sequence seq_restart;
    (r.st == ST_CONVERT) && r.conv_start && r.sdo;
  endsequence

  AST_POR_HOLD: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !sup_s |=> (r.st == ST_POR) && r.sdo_oe_n) else $error("supply low without reset");
  AST_POR_LEN: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (r.st == ST_POR) && (r.st != $past(r.st)) |-> (r.por_cnt == 16'h0))
    else $error("power-on clear did not start from zero");
  AST_POR_EXIT: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $past(r.st) == ST_POR && r.st == ST_CONVERT |-> r.conv_start &&
    $past(r.por_cnt) == 16'(POR_CYCLES - 1)) else $error("power-on clear wrong length");
  AST_FRAME_EOC: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (r.st == ST_CONVERT) && conv_done && sup_s |=> !r.frame[`EOC_BIT] && (r.st == ST_SLEEP))
    else $error("loaded frame has end-of-conversion high");
  AST_SIGN_EXR: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (r.st == ST_CONVERT) && conv_done && sup_s |=>
    r.frame[`SIGN_BIT] == !$past(conv_value[31]) &&
    r.frame[`EXR_BIT] == ($past(signed'(conv_value)) > `FULL_SCALE || $past(conv_value[31])))
    else $error("sign or range flag wrong");
  AST_CHAN: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (r.st == ST_CONVERT) && conv_done && sup_s |=>
    r.frame[`CHAN_BIT] == ((CHANNELS == 2) ? $past(conv_channel) : 1'b0))
    else $error("channel bit wrong");
  AST_DESELECT_FLOAT: assert property (@(posedge sys_clk) disable iff (!arst_n)
    cs_s |=> r.sdo_oe_n) else $error("data out driven while deselected");
  AST_RESTART_32: assert property (@(posedge sys_clk) disable iff (!arst_n)
    seq_last_fall |=> seq_restart) else $error("no restart after 32nd fall");
  AST_ABORT: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (r.st == ST_OUTPUT) && cs_rise && sup_s |=> (r.st == ST_CONVERT) && r.sdo_oe_n)
    else $error("deselect did not abort transfer");
  AST_LIVE_EOC: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (r.st == ST_CONVERT) && !cs_s && sup_s ##1 (r.st == ST_SLEEP) && !cs_s && sup_s
    |=> !r.sdo) else $error("end-of-conversion did not fall");
  AST_INT_FIRST_RISE: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (r.st == ST_SLEEP) && !cs_s && sup_s |=>
    (r.st == ST_OUTPUT) && (r.sck_out == !r.mode_int))
    else $error("serial clock did not start in its low phase");

endmodule // adc_serial_result_readout

`default_nettype wire

// *** tb/rd_host_model.sv ***
// Serial host model: chip select, serial clock and frame capture.
`timescale 1ns/1ps
`default_nettype none

module rd_host_model (
  input  wire logic sys_clk,  // System clock.
  input  wire logic sck_out,  // Device serial clock level.
  input  wire logic sck_oe_n, // Device serial clock enable, active low.
  input  wire logic sdo,      // Device data out.
  output logic      cs_n,     // Chip select, active low.
  output logic      sck_in    // Resolved serial clock line.
);
  logic host_sck = 1'b0;
  logic ext_drv  = 1'b0;
  initial cs_n = 1'b1;
  assign sck_in = !sck_oe_n ? sck_out : (ext_drv ? host_sck : 1'b1);

  task select(input bit ext);
    @(negedge sys_clk);
    ext_drv  = ext;
    host_sck = 1'b0;
    @(negedge sys_clk);
    cs_n = 1'b0;
  endtask

  task clock_frame(input bit ext, input int n, output logic [31:0] f);
    f = '0;
    for (int i = 0; i < n; i++) begin
      if (ext) begin
        repeat (4) @(negedge sys_clk);
        host_sck = 1'b1;
      end else begin
        while (sck_in !== 1'b0) @(negedge sys_clk);
        while (sck_in !== 1'b1) @(negedge sys_clk);
      end
      f = {f[30:0], sdo};
      if (ext) begin
        repeat (4) @(negedge sys_clk);
        host_sck = 1'b0;
      end
    end
  endtask

  task deselect();
    @(negedge sys_clk);
    cs_n    = 1'b1;
    ext_drv = 1'b0;
  endtask
endmodule // rd_host_model

`default_nettype wire

// *** tb/adc_serial_result_readout_bench.sv ***
// Testbench for the serial result readout.
`timescale 1ns/1ps
`default_nettype none
`include "adc_readout_defs.svh"

module adc_serial_result_readout_bench;
  logic        sys_clk;
  logic        arst_n;
  logic        supply_ok;
  logic        conv_done;
  logic [31:0] conv_value;
  logic        conv_channel;
  wire logic   cs_n;
  wire logic   sck_in;
  logic        sck_out;
  logic        sck_oe_n;
  logic        sdo;
  logic        sdo_oe_n;
  logic        conv_start;
  logic        mode_int;
  int          bad_count = 0;
  int          checked   = 0;
  logic [31:0] vals [5] = '{32'h0fffffff, 32'h20000000, 32'h0, 32'hffffffff, 32'h80000000};

  adc_serial_result_readout #(.CHANNELS(2), .POR_CYCLES(4)) i_adc_serial_result_readout (
    .sys_clk(sys_clk), .arst_n(arst_n), .supply_ok(supply_ok), .conv_done(conv_done),
    .conv_value(conv_value), .conv_channel(conv_channel), .cs_n(cs_n), .sck_in(sck_in),
    .sck_out(sck_out), .sck_oe_n(sck_oe_n), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
    .conv_start(conv_start), .mode_int(mode_int));

  rd_host_model i_rd_host_model (
    .sys_clk(sys_clk), .sck_out(sck_out), .sck_oe_n(sck_oe_n), .sdo(sdo),
    .cs_n(cs_n), .sck_in(sck_in));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask

  task end_sim();
    if (bad_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  function automatic logic [31:0] exp_frame(input logic signed [31:0] v, input logic ch);
    logic signed [31:0] c;
    c = (v > `CLAMP_HI) ? `CLAMP_HI : (v < `CLAMP_LO) ? `CLAMP_LO : v;
    return {1'b0, ch, v >= 0, (v < 0) || (v > `FULL_SCALE), c[27:0]};
  endfunction

  task wait_start(input int n);
    int k;
    k = 0;
    while (conv_start !== 1'b1 && k < n) begin
      @(negedge sys_clk);
      k++;
    end
    chk("conv_start", 1, conv_start);
  endtask

  task finish_conv(input logic [31:0] v, input logic ch);
    @(negedge sys_clk);
    conv_done    = 1'b1;
    conv_value   = v;
    conv_channel = ch;
    @(negedge sys_clk);
    conv_done = 1'b0;
  endtask

  task frame_run(input logic [31:0] v, input logic ch, input bit ext);
    logic [31:0] f;
    i_rd_host_model.select(ext);
    repeat (5) @(negedge sys_clk);
    chk("eoc_busy", 1, sdo);
    chk("mode_int", !ext, mode_int);
    finish_conv(v, ch);
    repeat (3) @(negedge sys_clk);
    chk("eoc_done", 0, sdo);
    i_rd_host_model.clock_frame(ext, 32, f);
    chk("frame", exp_frame(v, ch), f);
    wait_start(20);
    chk("eoc_next", 1, sdo);
    i_rd_host_model.deselect();
    repeat (4) @(negedge sys_clk);
    chk("sdo_float", 1, sdo_oe_n);
  endtask

  task test_abort();
    logic [31:0] f;
    i_rd_host_model.select(1'b1);
    repeat (5) @(negedge sys_clk);
    finish_conv(32'h05a5a5a5, 1'b0);
    i_rd_host_model.clock_frame(1'b1, 10, f);
    chk("partial", exp_frame(32'h05a5a5a5, 1'b0) >> 22, f[9:0]);
    i_rd_host_model.deselect();
    wait_start(10);
    repeat (2) @(negedge sys_clk);
    chk("abort_float", 1, sdo_oe_n);
  endtask

  task test_supply();
    i_rd_host_model.select(1'b0);
    supply_ok = 1'b0;
    repeat (6) @(negedge sys_clk);
    chk("por_float", 1, sdo_oe_n);
    supply_ok = 1'b1;
    wait_start(12);
    chk("por_mode", 1, mode_int);
    i_rd_host_model.deselect();
  endtask

  initial begin
    #800000;
    bad_count++;
    end_sim();
  end

  initial begin
    arst_n       = 1'b0;
    supply_ok    = 1'b0;
    conv_done    = 1'b0;
    conv_value   = '0;
    conv_channel = 1'b0;
    repeat (8) @(negedge sys_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk("reset_float", 1, sdo_oe_n);
    supply_ok = 1'b1;
    wait_start(12);
    for (int i = 0; i < 5; i++) frame_run(vals[i], i[0], 1'b1);
    frame_run(32'h01234567, 1'b1, 1'b0);
    test_abort();
    test_supply();
    end_sim();
  end
endmodule // adc_serial_result_readout_bench

`default_nettype wire
